// *** core/clock_trim_and_reset_control.sv ***
// Operation
// - trim bits 7:4 fine, higher is faster
// - bit 3 coarse faster, bit 2 coarse slower
// - clock output only in codes 101, 111
// - clock output runs at oscillator over four
// - five reset causes told apart
// - some registers keep contents except power-on
// - watchdog wake keeps trim and select, clears timeout and powerdown flags
// - master clear input filtered against glitches
// - watchdog reset never drives master clear
// - master clear, clock output mode: pin low
// - master clear, io mode: pin tristate input
// - master clear, RC modes: input pin tristate
// - select codes 111,110,101,100 for RC modes
// - power-on sets timeout and powerdown flags
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "clk_rst_cfg.svh"

module clock_trim_and_reset_control #(
  parameter int FILTER_CYC = `MASTER_CLEAR_PIN_FILTER_CYC,
  parameter int DIV        = `DIVIDED_CLOCK_OUTPUT_DIV
) (
  // clock, reset, enable
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  // register port
  input  wire logic [3:0]              addr,
  input  wire logic [7:0]              wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output clk_rst_pkg::byte_t           rdata,
  // reset event inputs
  input  wire logic                    por_evt,
  input  wire logic                    wdt_evt,
  input  wire logic                    sleeping,
  input  wire logic                    master_clear_pin_pin_n,
  // oscillator pins
  input  wire logic                    osc_out_pin_in,
  input  wire logic                    gpio_out,
  input  wire logic                    gpio_oe,
  output logic                         osc_out_pin_o,
  output logic                         osc_out_pin_oe,
  output logic                         osc_in_pin_oe,
  // trim and reset outputs
  output clk_rst_pkg::byte_t           trim_value,
  output logic                         core_reset,
  output clk_rst_pkg::reset_cause_e    last_cause
);
  import clk_rst_pkg::*;

  // ****************************************
  // state
  // ****************************************
  byte_t        trim_ff;
  osc_sel_t     osc_sel_ff;
  logic         timeout_flag_ff;
  logic         powerdown_flag_ff;
  reset_cause_e cause_ff;
  logic         master_clear_pin_prev_ff;
  logic         core_reset_ff;
  byte_t        rdata_ff;
  logic         master_clear_pin_asserted;
  logic         div_clk;
  logic         master_clear_pin_rise;
  logic         any_reset;
  logic         divided_clock_output_mode;
  logic         io_mode;

  assign trim_value = trim_ff;
  assign rdata      = rdata_ff;
  assign last_cause = cause_ff;
  assign core_reset = core_reset_ff;

  // ****************************************
  // master clear filter and divider
  // ****************************************
  master_clear_pin_filter #(
    .FILTER_CYC (FILTER_CYC)
  ) u_filter (
    .clk           (clk),
    .rst_n         (rst_n),
    .ce            (ce),
    .master_clear_pin_pin_n    (master_clear_pin_pin_n),
    .master_clear_pin_asserted (master_clear_pin_asserted)
  );

  assign master_clear_pin_rise = master_clear_pin_asserted && !master_clear_pin_prev_ff;
  assign any_reset = por_evt || master_clear_pin_rise || (wdt_evt && !sleeping);

  divided_clock_output_div #(
    .DIV (DIV)
  ) u_div (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .clear   (any_reset || core_reset_ff),
    .div_clk (div_clk)
  );

  // ****************************************
  // oscillator pin control
  // ****************************************
  assign divided_clock_output_mode = (osc_sel_ff == `OSC_INTERNAL_RC_MODE_DIVIDED_CLOCK_OUTPUT) ||
                       (osc_sel_ff == `OSC_EXTERNAL_RC_MODE_DIVIDED_CLOCK_OUTPUT);
  assign io_mode     = (osc_sel_ff == `OSC_INTERNAL_RC_MODE_IO) ||
                       (osc_sel_ff == `OSC_EXTERNAL_RC_MODE_IO);

  always_comb begin
    osc_out_pin_o  = 1'b0;
    osc_out_pin_oe = 1'b0;
    if (divided_clock_output_mode) begin
      osc_out_pin_oe = 1'b1;
      // held low throughout master clear
      osc_out_pin_o  = master_clear_pin_asserted ? 1'b0 : div_clk;
    end else if (io_mode && !master_clear_pin_asserted) begin
      osc_out_pin_oe = gpio_oe;
      osc_out_pin_o  = gpio_out;
    end // io mode under master clear stays an input
  end

  // the input pin is never driven here in RC modes
  assign osc_in_pin_oe = 1'b0;

  // ****************************************
  // reset sequencing
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      master_clear_pin_prev_ff  <= 1'b0;
      core_reset_ff <= 1'b1;
    end else if (ce) begin
      master_clear_pin_prev_ff  <= master_clear_pin_asserted;
      // watchdog only acts internally, pin is an input only
      core_reset_ff <= any_reset || master_clear_pin_asserted;
    end
  end

  // priority: power-on, then master clear, then watchdog
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cause_ff          <= cause_none;
      timeout_flag_ff   <= 1'b1;
      powerdown_flag_ff <= 1'b1;
    end else if (ce) begin
      if (por_evt) begin
        cause_ff          <= cause_por;
        timeout_flag_ff   <= 1'b1;
        powerdown_flag_ff <= 1'b1;
      end else if (master_clear_pin_rise && sleeping) begin
        cause_ff          <= cause_master_clear_pin_sleep;
        timeout_flag_ff   <= 1'b1;
        powerdown_flag_ff <= 1'b0;
      end else if (master_clear_pin_rise) begin
        cause_ff <= cause_master_clear_pin_run;
      end else if (wdt_evt && sleeping) begin
        cause_ff          <= cause_wdt_wake;
        timeout_flag_ff   <= 1'b0;
        powerdown_flag_ff <= 1'b0;
      end else if (wdt_evt) begin
        cause_ff        <= cause_wdt_run;
        timeout_flag_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  // select stands for the configuration word: only power-on reloads it,
  // otherwise a clear in io mode would flip the pin into clock mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_sel_ff <= `OSC_SEL_RESET;
    end else if (ce) begin
      if (por_evt) begin
        osc_sel_ff <= `OSC_SEL_RESET;
      end else if (wr && addr == `ADDR_OSC_SEL) begin
        osc_sel_ff <= wdata[2:0];
      end
    end
  end

  // trim loads a known value only at power-on, other resets keep it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trim_ff <= `TRIM_POR_VALUE;
    end else if (ce) begin
      if (por_evt) begin
        trim_ff <= `TRIM_POR_VALUE;
      end else if (wr && addr == `ADDR_TRIM) begin
        // low two bits unimplemented, dropped even if written
        trim_ff <= wdata & `TRIM_IMPL_MASK;
      end
    end
  end

  // ****************************************
  // read port
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (ce) begin
      rdata_ff <= 8'h00;
      if (rd) begin
        case (addr)
          `ADDR_TRIM:     rdata_ff <= trim_ff;
          `ADDR_OSC_SEL:  rdata_ff <= {5'h00, osc_sel_ff};
          `ADDR_STATUS:   rdata_ff <= {5'h00, master_clear_pin_asserted, timeout_flag_ff, powerdown_flag_ff};
          `ADDR_CAUSE:    rdata_ff <= {5'h00, cause_ff};
          `ADDR_TRIM_OUT: rdata_ff <= {4'h0, trim_ff[`TRIM_FINE_HI:`TRIM_FINE_LO]};
          default:        rdata_ff <= 8'h00;
        endcase
      end
    end
  end
endmodule : clock_trim_and_reset_control

// *** core/clk_rst_cfg.svh ***
`ifndef CLK_RST_CFG_SVH
`define CLK_RST_CFG_SVH

// ****************************************
// register map
// ****************************************
`define ADDR_TRIM          4'h0
`define ADDR_OSC_SEL       4'h1
`define ADDR_STATUS        4'h2
`define ADDR_CAUSE         4'h3
`define ADDR_TRIM_OUT      4'h4

// ****************************************
// trim field layout
// ****************************************
`define TRIM_FINE_HI       7
`define TRIM_FINE_LO       4
`define TRIM_FAST_BIT      3
`define TRIM_SLOW_BIT      2
`define TRIM_IMPL_MASK     8'hfc
`define TRIM_POR_VALUE     8'h70

// ****************************************
// oscillator select codes
// ****************************************
`define OSC_EXTERNAL_RC_MODE_DIVIDED_CLOCK_OUTPUT   3'h7
`define OSC_EXTERNAL_RC_MODE_IO       3'h6
`define OSC_INTERNAL_RC_MODE_DIVIDED_CLOCK_OUTPUT   3'h5
`define OSC_INTERNAL_RC_MODE_IO       3'h4
`define OSC_SEL_RESET      3'h5

// ****************************************
// status bits and timing
// ****************************************
`define STAT_TIMEOUT_BIT   1
`define STAT_PWRDN_BIT     0
`define MASTER_CLEAR_PIN_FILTER_NS     20
`define CLK_PERIOD_NS      5
`define MASTER_CLEAR_PIN_FILTER_CYC    ((`MASTER_CLEAR_PIN_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DIVIDED_CLOCK_OUTPUT_DIV         4

`endif

// *** core/clk_rst_pkg.sv ***
package clk_rst_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] osc_sel_t;
  typedef enum logic [2:0] {
    cause_none,
    cause_por,
    cause_master_clear_pin_run,
    cause_master_clear_pin_sleep,
    cause_wdt_run,
    cause_wdt_wake
  } reset_cause_e;
endpackage : clk_rst_pkg

// *** core/master_clear_pin_filter.sv ***
`timescale 1ns/1ps
`include "clk_rst_cfg.svh"

module master_clear_pin_filter #(
  parameter int FILTER_CYC = `MASTER_CLEAR_PIN_FILTER_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // pin and result
  input  wire logic master_clear_pin_pin_n,
  output logic      master_clear_pin_asserted
);
  logic [7:0] cnt_ff;
  logic       state_ff;

  assign master_clear_pin_asserted = state_ff;

  // a change must persist FILTER_CYC cycles before it is believed
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff   <= 8'h00;
      state_ff <= 1'b0;
    end else if (ce) begin
      if ((!master_clear_pin_pin_n) == state_ff) begin
        cnt_ff <= 8'h00;
      end else if (cnt_ff >= 8'(FILTER_CYC - 1)) begin
        cnt_ff   <= 8'h00;
        state_ff <= !master_clear_pin_pin_n;
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end
endmodule : master_clear_pin_filter

// *** core/divided_clock_output_div.sv ***
`timescale 1ns/1ps
`include "clk_rst_cfg.svh"

module divided_clock_output_div #(
  parameter int DIV = `DIVIDED_CLOCK_OUTPUT_DIV
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // control
  input  wire logic clear,
  output logic      div_clk
);
  logic [7:0] cnt_ff;
  logic       out_ff;

  assign div_clk = out_ff;

  // half period of DIV/2 osc cycles, so one output period per DIV cycles
  always_ff @(posedge clk) begin
    if (!rst_n || (ce && clear)) begin
      cnt_ff <= 8'h00;
      out_ff <= 1'b0;
    end else if (ce) begin
      if (cnt_ff == 8'(DIV / 2 - 1)) begin
        cnt_ff <= 8'h00;
        out_ff <= ~out_ff;
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end
endmodule : divided_clock_output_div

// *** testbench/ctrc_sva.sv ***
`timescale 1ns/1ps
// ****
// reset and pin checks
// ****
module ctrc_sva (
  // watched ports
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic                 ce,
  input wire logic [3:0]           addr,
  input wire logic [7:0]           wdata,
  input wire logic                 wr,
  input wire logic                 rd,
  input clk_rst_pkg::byte_t        rdata,
  input wire logic                 por_evt,
  input wire logic                 wdt_evt,
  input wire logic                 sleeping,
  input wire logic                 master_clear_pin_pin_n,
  input wire logic                 osc_out_pin_o,
  input wire logic                 osc_out_pin_oe,
  input wire logic                 osc_in_pin_oe,
  input clk_rst_pkg::byte_t        trim_value,
  input wire logic                 core_reset,
  input clk_rst_pkg::reset_cause_e last_cause
);
  import clk_rst_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire quiet = ce && master_clear_pin_pin_n && !por_evt;
  wire idle  = quiet && !wdt_evt;
  // a reset or mode change may cut a clock phase short
  wire brk   = core_reset || !osc_out_pin_oe || !ce;
  sequence calm; idle [*6]; endsequence

  a_trim_write: assert property (wr && ce && !core_reset && !por_evt && addr == 4'h0
    |=> trim_value == ($past(wdata) & 8'hfc)) else $error("trim write not applied");
  a_read_trim: assert property (rd && ce && !core_reset && addr == 4'h0
    |=> rdata == $past(trim_value)) else $error("trim read mismatch");
  a_in_pin_hiz: assert property (osc_in_pin_oe == 1'b0) else $error("input pin driven");
  a_master_clear_pin_pin_low: assert property ((ce && !master_clear_pin_pin_n) [*6]
    |-> !osc_out_pin_o || !osc_out_pin_oe) else $error("output pin high under clear");
  a_glitch_ignored: assert property (calm ##1 (ce && !master_clear_pin_pin_n && !por_evt && !wdt_evt) ##1 idle [*6]
    |-> !core_reset) else $error("glitch caused reset");
  a_wdt_run: assert property (calm ##1 (quiet && wdt_evt && !sleeping)
    |=> core_reset && last_cause == cause_wdt_run) else $error("watchdog reset missed");
  a_wdt_wake: assert property (calm ##1 (quiet && wdt_evt && sleeping)
    |=> !core_reset && last_cause == cause_wdt_wake) else $error("watchdog wake reset");
  a_por_load: assert property (por_evt && ce
    |=> core_reset && last_cause == cause_por && trim_value == 8'h70) else $error("power-on load wrong");
  a_divided_clock_output_period: assert property ($rose(osc_out_pin_o) && $past(osc_out_pin_oe) && !brk
    |=> (osc_out_pin_o || brk) ##1 (!osc_out_pin_o || brk)) else $error("clock out phase wrong");

  c_wake: cover property (calm ##1 (quiet && wdt_evt && sleeping));
  c_clear: cover property ((ce && !master_clear_pin_pin_n) [*6]);
  c_cause_rd: cover property (rd && addr == 4'h3);
endmodule : ctrc_sva

bind clock_trim_and_reset_control ctrc_sva u_sva (.clk, .rst_n, .ce, .addr, .wdata, .wr, .rd, .rdata,
  .por_evt, .wdt_evt, .sleeping, .master_clear_pin_pin_n, .osc_out_pin_o, .osc_out_pin_oe, .osc_in_pin_oe,
  .trim_value, .core_reset, .last_cause);

// *** testbench/divided_clock_output_follower.sv ***
`timescale 1ns/1ps
// ****
// logic clocked from the divided output
// ****
module divided_clock_output_follower (
  // pin level
  input wire logic pin,
  // rising edges seen
  output int       n_rise
);
  int rise_cnt = 0;

  assign n_rise = rise_cnt;
  always @(posedge pin) rise_cnt <= rise_cnt + 1;
endmodule : divided_clock_output_follower

// *** testbench/test_clock_trim_and_reset_control.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
// ****
// bench
// ****
module test_clock_trim_and_reset_control;
  import clk_rst_pkg::*;
  typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] e;} row_s;
  localparam byte_t FACTORY_TRIM = 8'h94; // arbitrary
  logic         clk = 1'b0, rst_n = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0;
  logic         por_evt = 1'b0, wdt_evt = 1'b0, sleeping = 1'b0, master_clear_pin_pin_n = 1'b1;
  logic         gpio_out = 1'b0, gpio_oe = 1'b0;
  logic [3:0]   addr = 4'h0;
  logic [7:0]   wdata = 8'h00, rv;
  byte_t        rdata, trim_value;
  reset_cause_e last_cause;
  logic         osc_out_pin_o, osc_out_pin_oe, osc_in_pin_oe, core_reset;
  int           n_tests = 0, n_mismatch = 0, e0, n_rise;
  // pull-up on the output pin when nobody drives it
  wire          pin = osc_out_pin_oe ? osc_out_pin_o : 1'b1;
  // software keeps trim bits 1:0 at zero
  row_s rows[9] = '{'{4'h0, 8'ha8, 8'ha8}, '{4'h0, 8'hf0, 8'hf0}, '{4'h0, 8'h08, 8'h08},
    '{4'h0, 8'h04, 8'h04}, '{4'h1, 8'h04, 8'h04}, '{4'h1, 8'h06, 8'h06}, '{4'h1, 8'h07, 8'h07},
    '{4'h1, 8'h05, 8'h05}, '{4'hf, 8'h55, 8'h00}};

  always #2.5 clk = ~clk;

  clock_trim_and_reset_control #(.FILTER_CYC(4), .DIV(4)) DUT (.clk, .rst_n, .ce, .addr, .wdata, .wr, .rd,
    .rdata, .por_evt, .wdt_evt, .sleeping, .master_clear_pin_pin_n, .osc_out_pin_in(pin), .gpio_out, .gpio_oe,
    .osc_out_pin_o, .osc_out_pin_oe, .osc_in_pin_oe, .trim_value, .core_reset, .last_cause);
  divided_clock_output_follower u_far (.pin(pin), .n_rise(n_rise));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask : rd_reg
  task automatic clear_pulse(input logic io);
    @(posedge clk);
    master_clear_pin_pin_n <= 1'b0;
    cyc(8);
    `CHK(core_reset, 1'b1)
    `CHK(osc_out_pin_oe, !io)
    `CHK(osc_out_pin_o, 1'b0)
    `CHK(osc_in_pin_oe, 1'b0)
    master_clear_pin_pin_n <= 1'b1;
    cyc(8);
  endtask : clear_pulse
  task automatic test_done;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  initial begin
    #20000;
    n_mismatch++;
    test_done();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a);
      `CHK(rv, rows[i].e)
      // codes 101 and 111 drive the pin, 100 and 110 leave it to gpio
      `CHK(osc_out_pin_oe, rows[i].a != 4'h1 || rows[i].d[0])
    end
    $display("register rows done");
    ce <= 1'b0;
    wr_reg(4'h0, 8'h00);
    cyc(1);
    `CHK(trim_value, 8'h04)
    ce <= 1'b1;
    wr_reg(4'h0, FACTORY_TRIM);
    @(posedge clk) master_clear_pin_pin_n <= 1'b0;
    @(posedge clk) master_clear_pin_pin_n <= 1'b1;
    cyc(8);
    `CHK(core_reset, 1'b0)
    clear_pulse(1'b0);
    `CHK(last_cause, cause_master_clear_pin_run)
    `CHK(trim_value, FACTORY_TRIM)
    rd_reg(4'h2);
    `CHK(rv, 8'h03)
    wr_reg(4'h1, 8'h04);
    gpio_oe <= 1'b1;
    sleeping <= 1'b1;
    clear_pulse(1'b1);
    `CHK(last_cause, cause_master_clear_pin_sleep)
    rd_reg(4'h2);
    `CHK(rv, 8'h02)
    sleeping <= 1'b0;
    $display("clear tests done");
    @(posedge clk) wdt_evt <= 1'b1;
    @(posedge clk) wdt_evt <= 1'b0;
    cyc(4);
    `CHK(last_cause, cause_wdt_run)
    `CHK(trim_value, FACTORY_TRIM)
    wr_reg(4'h1, 8'h04);
    sleeping <= 1'b1;
    cyc(8);
    @(posedge clk) wdt_evt <= 1'b1;
    @(posedge clk) wdt_evt <= 1'b0;
    cyc(4);
    `CHK(last_cause, cause_wdt_wake)
    rd_reg(4'h1);
    `CHK(rv, 8'h04)
    rd_reg(4'h2);
    `CHK(rv, 8'h00)
    sleeping <= 1'b0;
    gpio_oe <= 1'b1;
    cyc(2);
    `CHK(osc_out_pin_oe, 1'b1)
    gpio_oe <= 1'b0;
    wr_reg(4'h1, 8'h05);
    $display("watchdog tests done");
    cyc(4);
    e0 = n_rise;
    cyc(40);
    `CHK(n_rise - e0, 10)
    @(posedge clk) por_evt <= 1'b1;
    @(posedge clk) por_evt <= 1'b0;
    cyc(4);
    `CHK(trim_value, 8'h70)
    `CHK(last_cause, cause_por)
    rd_reg(4'h2);
    `CHK(rv, 8'h03)
    rst_n <= 1'b0;
    cyc(2);
    `CHK(last_cause, cause_none)
    `CHK(osc_out_pin_o, 1'b0)
    rst_n <= 1'b1;
    $display("clock and power-on tests done");
    test_done();
  end
endmodule : test_clock_trim_and_reset_control
